// ===== rtl/isp_port_ctrl.sv
// Serial test port enable, extension pins, flash sequencing and reset effects
module isp_port_ctrl
    import isp_port_pkg::*;
#(
    parameter int SECTORS = 12,
    parameter logic [7:0] MMAP_INIT = 8'h00
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic power_on_rst,
    input wire logic clk_en,
    input wire logic nvm_port_dedicated,
    input wire logic port_select_product_term,
    input wire logic blank_device,
    input wire logic security_bit,
    input wire logic [SECTORS-1:0] sector_protect,
    input wire logic cfg_loaded,
    input wire logic tck_pin,
    input wire logic tms_pin,
    input wire logic tdi_pin,
    input wire logic flash_done,
    input wire logic flash_fail,
    input wire logic [7:0] flash_rdata,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic port_on,
    output logic tdo_out,
    output logic tdo_oe,
    output logic isp_status_out,
    output logic isp_status_oe,
    output logic isp_error_out,
    output logic isp_error_oe,
    output logic [1:0] flash_op,
    output logic [7:0] flash_target,
    output logic [7:0] flash_wdata,
    output logic flash_abort,
    output logic sram_in_code_space_bit,
    output logic peripheral_access_bit,
    output logic [7:0] power_mode_reg_a,
    output logic [7:0] power_mode_reg_b,
    output logic pld_outputs_valid,
    output logic macrocell_clear
);
    localparam int SW = $clog2(SECTORS);

    typedef struct packed {
        logic [2:0] tck_q;
        logic [2:0] tms_q;
        logic [2:0] tdi_q;
        logic tck_f;
        logic tms_f;
        logic tdi_f;
        tap_t tap;
        logic [7:0] ir_sh;
        logic [7:0] ir;
        logic [15:0] dr;
        logic tdo;
        logic tdo_oe;
        logic port_on;
        logic isc_on;
        logic ext_od;
        logic disabled;
        logic err;
        logic wiped;
        logic refused;
        flash_t fl;
        logic [1:0] fl_op;
        logic [7:0] fl_tgt;
        logic [7:0] fl_wd;
        logic fl_abort;
        logic port_en;
        logic [7:0] mmap;
        logic [7:0] pm_a;
        logic [7:0] pm_b;
        logic [7:0] rdata;
        logic stat_out;
        logic stat_oe;
        logic err_out;
        logic err_oe;
        logic pld_valid;
        logic mcell_clr;
    } state_t;

    state_t s;
    state_t next_s;

    function automatic tap_t tap_step(tap_t st, logic m);
        tap_t r;
        r = st;
        case (st)
            TLR: r = m ? TLR : RTI;
            RTI: r = m ? SEL_DR : RTI;
            SEL_DR: r = m ? SEL_IR : CAP_DR;
            CAP_DR: r = m ? EX1_DR : SH_DR;
            SH_DR: r = m ? EX1_DR : SH_DR;
            EX1_DR: r = m ? UPD_DR : PA_DR;
            PA_DR: r = m ? EX2_DR : PA_DR;
            EX2_DR: r = m ? UPD_DR : SH_DR;
            UPD_DR: r = m ? SEL_DR : RTI;
            SEL_IR: r = m ? TLR : CAP_IR;
            CAP_IR: r = m ? EX1_IR : SH_IR;
            SH_IR: r = m ? EX1_IR : SH_IR;
            EX1_IR: r = m ? UPD_IR : PA_IR;
            PA_IR: r = m ? EX2_IR : PA_IR;
            EX2_IR: r = m ? UPD_IR : SH_IR;
            UPD_IR: r = m ? SEL_DR : RTI;
            default: r = TLR;
        endcase
        return r;
    endfunction

    logic rise;
    logic fall;
    logic blank;
    logic dedicated;
    logic secured;
    logic set_err;
    logic clr_err;
    logic data_ir;
    logic prot;
    logic [SW-1:0] sec_idx;

    always_comb begin
        next_s = s;
        rise = 1'b0;
        fall = 1'b0;
        set_err = 1'b0;
        clr_err = 1'b0;
        prot = 1'b0;
        sec_idx = s.dr[8 +: SW];
        blank = blank_device | s.wiped;
        dedicated = nvm_port_dedicated | blank;
        secured = security_bit & ~s.wiped;
        data_ir = (s.ir == OP_PROGRAM) || (s.ir == OP_ERASE) || (s.ir == OP_READ);
        if (clk_en) begin
            // Pins are asynchronous: a level counts once two late stages agree
            next_s.tck_q = {s.tck_q[1:0], tck_pin};
            next_s.tms_q = {s.tms_q[1:0], tms_pin};
            next_s.tdi_q = {s.tdi_q[1:0], tdi_pin};
            if (s.tck_q[1] == s.tck_q[2]) begin
                next_s.tck_f = s.tck_q[2];
            end
            if (s.tms_q[1] == s.tms_q[2]) begin
                next_s.tms_f = s.tms_q[2];
            end
            if (s.tdi_q[1] == s.tdi_q[2]) begin
                next_s.tdi_f = s.tdi_q[2];
            end
            rise = next_s.tck_f & ~s.tck_f;
            fall = ~next_s.tck_f & s.tck_f;
            next_s.fl_abort = 1'b0;

            next_s.port_on = dedicated | s.port_en | port_select_product_term;

            if (s.port_on && rise) begin
                next_s.tap = tap_step(s.tap, s.tms_f);
                case (s.tap)
                    TLR: next_s.ir = OP_BYPASS;
                    CAP_IR: begin
                        next_s.ir_sh = IR_CAPTURE;
                    end
                    SH_IR: begin
                        next_s.ir_sh = {s.tdi_f, s.ir_sh[7:1]};
                    end
                    UPD_IR: begin
                        // Unknown codes fall back to the one-bit bypass path
                        next_s.ir = s.ir_sh;
                        case (s.ir_sh)
                            OP_ISC_ENABLE: begin
                                next_s.isc_on = 1'b1;
                                next_s.ext_od = 1'b0;
                            end
                            OP_ISC_ENABLE_OD: begin
                                next_s.isc_on = 1'b1;
                                next_s.ext_od = 1'b1;
                            end
                            OP_ISC_DISABLE: begin
                                next_s.isc_on = 1'b0;
                                next_s.disabled = 1'b1;
                            end
                            OP_ISC_CLEAR: begin
                                clr_err = 1'b1;
                            end
                            default: next_s.disabled = s.disabled;
                        endcase
                    end
                    CAP_DR: begin
                        if (s.ir == OP_READ) begin
                            if (secured || !s.isc_on) begin
                                next_s.dr[7:0] = 8'h00;
                                next_s.refused = 1'b1;
                            end else begin
                                next_s.dr[7:0] = flash_rdata;
                            end
                        end else if (!data_ir) begin
                            next_s.dr[0] = 1'b0;
                        end
                    end
                    SH_DR: begin
                        if (data_ir) begin
                            next_s.dr = {s.tdi_f, s.dr[15:1]};
                        end else begin
                            next_s.dr[0] = s.tdi_f;
                        end
                    end
                    UPD_DR: begin
                        prot = (32'(sec_idx) >= SECTORS) || sector_protect[sec_idx];
                        if (s.isc_on && (s.ir == OP_CHIP_ERASE || s.ir == OP_PROGRAM
                                || s.ir == OP_ERASE)) begin
                            if (s.fl == FL_BUSY) begin
                                next_s.refused = 1'b1;
                            end else if (s.ir == OP_CHIP_ERASE) begin
                                next_s.fl = FL_BUSY;
                                next_s.fl_op = FOP_CHIP;
                            end else if (secured) begin
                                next_s.refused = 1'b1;
                            end else if (s.ir == OP_ERASE && prot) begin
                                next_s.refused = 1'b1;
                            end else begin
                                next_s.fl = FL_BUSY;
                                next_s.fl_op = (s.ir == OP_ERASE) ? FOP_ERASE : FOP_PROGRAM;
                                next_s.fl_tgt = s.dr[15:8];
                                next_s.fl_wd = s.dr[7:0];
                            end
                        end
                    end
                    default: begin
                        next_s.ir_sh = s.ir_sh;
                    end
                endcase
            end
            if (s.port_on && fall) begin
                if (s.tap == SH_IR) begin
                    next_s.tdo = s.ir_sh[0];
                end else if (s.tap == SH_DR) begin
                    next_s.tdo = s.dr[0];
                end
            end
            if (!s.port_on) begin
                next_s.tap = TLR;
                next_s.isc_on = 1'b0;
            end

            // Flash sequencer completion
            if (s.fl == FL_BUSY && flash_done) begin
                next_s.fl = FL_READ;
                next_s.fl_op = FOP_NONE;
                if (flash_fail) begin
                    set_err = 1'b1;
                end else if (s.fl_op == FOP_CHIP) begin
                    next_s.wiped = 1'b1;
                end
            end
            // A failure in the same cycle as a clear keeps the flag set
            next_s.err = (s.err & ~clr_err) | set_err;

            // Extension pins: status mirrors read mode, error is active low
            next_s.stat_out = s.ext_od ? 1'b0 : (s.fl == FL_READ);
            next_s.stat_oe = s.isc_on & (~s.ext_od | (s.fl != FL_READ));
            next_s.err_out = s.ext_od ? 1'b0 : ~s.err;
            next_s.err_oe = s.isc_on & (~s.ext_od | s.err);

            if (reg_wr) begin
                case (reg_addr)
                    PORT_EN_OFS: next_s.port_en = reg_wdata[PORT_EN_BIT];
                    MMAP_OFS: next_s.mmap = reg_wdata;
                    PM_A_OFS: next_s.pm_a = reg_wdata;
                    PM_B_OFS: next_s.pm_b = reg_wdata;
                    STATUS_OFS: next_s.refused = 1'b0;
                    default: next_s.rdata = s.rdata;
                endcase
            end
            if (reg_rd) begin
                case (reg_addr)
                    PORT_EN_OFS: next_s.rdata = {7'h00, s.port_en};
                    MMAP_OFS: next_s.rdata = s.mmap;
                    PM_A_OFS: next_s.rdata = s.pm_a;
                    PM_B_OFS: next_s.rdata = s.pm_b;
                    STATUS_OFS: begin
                        next_s.rdata = 8'h00;
                        next_s.rdata[ST_PORT] = s.port_on;
                        next_s.rdata[ST_ISC] = s.isc_on;
                        next_s.rdata[ST_BUSY] = (s.fl == FL_BUSY);
                        next_s.rdata[ST_ERR] = s.err;
                        next_s.rdata[ST_SEC] = secured;
                        next_s.rdata[ST_REFUSED] = s.refused;
                        next_s.rdata[ST_BLANK] = blank;
                    end
                    default: next_s.rdata = 8'h00;
                endcase
            end else begin
                next_s.rdata = 8'h00;
            end

            if (sys_rst || power_on_rst) begin
                next_s.fl = FL_READ;
                next_s.fl_op = FOP_NONE;
                next_s.fl_abort = (s.fl == FL_BUSY);
                next_s.port_en = 1'b0;
                next_s.port_on = dedicated | port_select_product_term;
                next_s.refused = 1'b0;
                next_s.rdata = REG_RESET;
                next_s.mmap = MMAP_INIT;
                next_s.mmap[SRAM_CODE_BIT] = 1'b0;
                next_s.mmap[PERIPH_BIT] = 1'b0;
                if (!dedicated || power_on_rst) begin
                    // Register-enabled port is held idle for the whole reset
                    next_s.tap = TLR;
                    next_s.ir = OP_BYPASS;
                    next_s.isc_on = 1'b0;
                end
                if (s.disabled) begin
                    next_s.err = 1'b0;
                    next_s.disabled = 1'b0;
                end
            end
            if (power_on_rst) begin
                next_s.pm_a = PM_RESET;
                next_s.pm_b = PM_RESET;
                next_s.wiped = 1'b0;
                next_s.err = 1'b0;
                next_s.disabled = 1'b0;
                next_s.ext_od = 1'b0;
                next_s.tdo = 1'b0;
                next_s.tdo_oe = 1'b0;
                next_s.port_on = 1'b0;
                next_s.ir_sh = 8'h00;
                next_s.dr = 16'h0000;
                next_s.fl_tgt = 8'h00;
                next_s.fl_wd = 8'h00;
                next_s.stat_out = 1'b0;
                next_s.stat_oe = 1'b0;
                next_s.err_out = 1'b0;
                next_s.err_oe = 1'b0;
                next_s.tck_f = 1'b0;
                next_s.tms_f = 1'b1;
                next_s.tdi_f = 1'b0;
                next_s.pld_valid = cfg_loaded;
                next_s.mcell_clr = 1'b1;
            end else begin
                next_s.pld_valid = s.pld_valid | cfg_loaded;
                next_s.mcell_clr = 1'b0;
            end
            // Follows the settled pin owner so the driver never outlives the port
            next_s.tdo_oe = next_s.port_on & next_s.isc_on;
        end
    end

    always_ff @(posedge ref_clk) begin
        s <= next_s;
    end

    assign reg_rdata = s.rdata;
    assign port_on = s.port_on;
    assign tdo_out = s.tdo;
    assign tdo_oe = s.tdo_oe;
    assign isp_status_out = s.stat_out;
    assign isp_status_oe = s.stat_oe;
    assign isp_error_out = s.err_out;
    assign isp_error_oe = s.err_oe;
    assign flash_op = s.fl_op;
    assign flash_target = s.fl_tgt;
    assign flash_wdata = s.fl_wd;
    assign flash_abort = s.fl_abort;
    assign sram_in_code_space_bit = s.mmap[SRAM_CODE_BIT];
    assign peripheral_access_bit = s.mmap[PERIPH_BIT];
    assign power_mode_reg_a = s.pm_a;
    assign power_mode_reg_b = s.pm_b;
    assign pld_outputs_valid = s.pld_valid;
    assign macrocell_clear = s.mcell_clr;
endmodule

// ===== rtl/isp_port_pkg.sv
// Constants and types shared by the serial test port control block
package isp_port_pkg;
    // Register offsets on the software port
    localparam logic [7:0] PORT_EN_OFS = 8'hc7;
    localparam logic [7:0] MMAP_OFS = 8'hc2;
    localparam logic [7:0] PM_A_OFS = 8'hb0;
    localparam logic [7:0] PM_B_OFS = 8'hb4;
    localparam logic [7:0] STATUS_OFS = 8'hc9;
    // Field positions
    localparam int PORT_EN_BIT = 0;
    localparam int SRAM_CODE_BIT = 3;
    localparam int PERIPH_BIT = 7;
    localparam int ST_PORT = 0;
    localparam int ST_ISC = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_ERR = 3;
    localparam int ST_SEC = 4;
    localparam int ST_REFUSED = 5;
    localparam int ST_BLANK = 6;
    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] PM_RESET = 8'h00;
    // Instruction codes of the configuration command set
    localparam logic [7:0] OP_ISC_ENABLE = 8'h0c;
    localparam logic [7:0] OP_ISC_ENABLE_OD = 8'h0d;
    localparam logic [7:0] OP_ISC_DISABLE = 8'h0f;
    localparam logic [7:0] OP_ISC_CLEAR = 8'h1f;
    localparam logic [7:0] OP_PROGRAM = 8'h1a;
    localparam logic [7:0] OP_ERASE = 8'h1b;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h1c;
    localparam logic [7:0] OP_READ = 8'h1d;
    localparam logic [7:0] OP_BYPASS = 8'hff;
    localparam logic [7:0] IR_CAPTURE = 8'h01;
    // Flash operation codes handed to the array
    localparam logic [1:0] FOP_NONE = 2'h0;
    localparam logic [1:0] FOP_PROGRAM = 2'h1;
    localparam logic [1:0] FOP_ERASE = 2'h2;
    localparam logic [1:0] FOP_CHIP = 2'h3;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_t;

    typedef enum logic {FL_READ, FL_BUSY} flash_t;
endpackage

// ===== testbench/isp_port_ctrl_props.sv
// Port-level assertions for the serial test port control block
module isp_port_ctrl_props
    import isp_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic power_on_rst,
    input wire logic clk_en,
    input wire logic nvm_port_dedicated,
    input wire logic port_select_product_term,
    input wire logic blank_device,
    input wire logic cfg_loaded,
    input wire logic flash_done,
    input wire logic flash_fail,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic port_on,
    input wire logic tdo_oe,
    input wire logic isp_status_out,
    input wire logic isp_status_oe,
    input wire logic isp_error_out,
    input wire logic [1:0] flash_op,
    input wire logic flash_abort,
    input wire logic sram_in_code_space_bit,
    input wire logic peripheral_access_bit,
    input wire logic [7:0] power_mode_reg_a,
    input wire logic [7:0] power_mode_reg_b,
    input wire logic pld_outputs_valid,
    input wire logic macrocell_clear
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (power_on_rst);
    // Status lags the operation by one cycle, hence two busy cycles before checking
    sequence busy_s;
        (flash_op != FOP_NONE)[*2];
    endsequence
    sequence idle_s;
        (flash_op == FOP_NONE)[*3];
    endsequence
    wire any_src = nvm_port_dedicated || port_select_product_term || blank_device;
    AST_PORT_SRC: assert property (clk_en && !sys_rst && any_src |=> port_on)
        else $error("pins not given to the port");
    AST_PORT_OFF: assert property (clk_en && sys_rst && !any_src |=> !port_on)
        else $error("port still on after reset");
    AST_PORT_REG: assert property (clk_en && !sys_rst && reg_wr && reg_addr == PORT_EN_OFS
        && reg_wdata[PORT_EN_BIT] |-> ##[1:2] port_on)
        else $error("enable write did not open the port");
    AST_TDO_OE: assert property (tdo_oe |-> port_on)
        else $error("data out driven while port off");
    AST_RDATA: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without a read");
    AST_MMAP_RST: assert property (clk_en && sys_rst |=>
        !sram_in_code_space_bit && !peripheral_access_bit)
        else $error("memory map bits kept over reset");
    AST_PM_KEEP: assert property (clk_en && sys_rst |=>
        $stable(power_mode_reg_a) && $stable(power_mode_reg_b))
        else $error("power mode changed by warm reset");
    AST_POR_CLR: assert property (disable iff (!clk_en) power_on_rst |=> macrocell_clear
        && power_mode_reg_a == PM_RESET && power_mode_reg_b == PM_RESET)
        else $error("power-on reset did not clear");
    AST_PLD: assert property (disable iff (!clk_en)
        power_on_rst |=> pld_outputs_valid == $past(cfg_loaded))
        else $error("logic output validity wrong in power-on reset");
    AST_MC_REL: assert property (clk_en && !power_on_rst |=> !macrocell_clear)
        else $error("macrocell clear outside power-on reset");
    AST_ABORT: assert property (clk_en && sys_rst && flash_op != FOP_NONE |=>
        flash_op == FOP_NONE && flash_abort)
        else $error("reset did not abort flash operation");
    AST_ABORT_PULSE: assert property (flash_abort |=> !flash_abort)
        else $error("abort longer than one cycle");
    AST_ST_BUSY: assert property (busy_s |-> !isp_status_out)
        else $error("status high while busy");
    AST_ST_READY: assert property (idle_s |-> isp_status_out || !isp_status_oe)
        else $error("status low while ready");
    AST_ERR: assert property (clk_en && flash_op != FOP_NONE && flash_done && flash_fail
        |-> ##[1:2] !isp_error_out)
        else $error("error pin not low after failure");
endmodule

bind isp_port_ctrl isp_port_ctrl_props i_props (.*);

// ===== testbench/isp_cable_model.sv
// Behavioural programming cable driving the serial test port pins
module isp_cable_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    // Data out seen just before each rising clock, newest bit at the top
    logic [31:0] tdo_seen = 32'h0;
    // Clock parks low between frames, as a cable does
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    task automatic tclk(input logic m, input logic d);
        tms = m;
        tdi = d;
        #62.5 tdo_seen = {tdo, tdo_seen[31:1]};
        tck = 1'b1;
        #62.5 tck = 1'b0;
    endtask
    // From idle: walk to shift, shift n bits LSB first, update, back to idle
    task automatic scan(input logic ir, input logic [15:0] v, input int n);
        tclk(1'b0, 1'b0);
        tclk(1'b1, 1'b0);
        if (ir) begin
            tclk(1'b1, 1'b0);
        end
        tclk(1'b0, 1'b0);
        tclk(1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            tclk(i == n - 1, v[i]);
        end
        tclk(1'b1, 1'b0);
        tclk(1'b0, 1'b0);
    endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the serial test port control block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import isp_port_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b0;
    logic power_on_rst = 1'b1;
    logic cfg_loaded = 1'b0;
    logic nvm_port_dedicated = 1'b0;
    logic port_select_product_term = 1'b0;
    logic blank_device = 1'b0;
    logic security_bit = 1'b0;
    logic [11:0] sector_protect = 12'h000;
    logic flash_done = 1'b0;
    logic flash_fail = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] flash_rdata = 8'ha5;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic tck_pin, tms_pin, tdi_pin, port_on, tdo_out, tdo_oe, flash_abort;
    logic isp_status_out, isp_status_oe, isp_error_out, isp_error_oe;
    logic sram_in_code_space_bit, peripheral_access_bit, pld_outputs_valid, macrocell_clear;
    logic [1:0] flash_op;
    logic [7:0] reg_rdata, flash_target, flash_wdata, power_mode_reg_a, power_mode_reg_b;
    int n_errors = 0;
    int total_checks = 0;

    isp_port_ctrl i_dut (.*);
    isp_cable_model i_cable (.tck(tck_pin), .tms(tms_pin), .tdi(tdi_pin), .tdo(tdo_out));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic end_of_test;
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    task automatic warm;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
    endtask
    // The array answers a started operation; f marks a failed one
    task automatic done(input logic f);
        @(posedge ref_clk);
        flash_done <= 1'b1;
        flash_fail <= f;
        @(posedge ref_clk);
        flash_done <= 1'b0;
        flash_fail <= 1'b0;
        tick(3);
    endtask

    initial begin
        logic [7:0] d;
        @(posedge ref_clk);
        cfg_loaded <= 1'b1;
        tick(0);
        chk({macrocell_clear, pld_outputs_valid}, 2'b10);
        @(posedge ref_clk);
        @(posedge ref_clk);
        power_on_rst <= 1'b0;
        tick(0);
        chk(pld_outputs_valid, 1'b1);
        tick(1);
        chk(macrocell_clear, 1'b0);
        rd(PM_B_OFS, d);
        chk(d, PM_RESET);
        rd(PORT_EN_OFS, d);
        chk(d, REG_RESET);
        wr(PM_A_OFS, 8'h5a);
        wr(MMAP_OFS, 8'h88);
        wr(PORT_EN_OFS, 8'h01);
        tick(1);
        chk({port_on, peripheral_access_bit, sram_in_code_space_bit}, 3'b111);
        rd(PORT_EN_OFS, d);
        chk(d, 8'h01);
        rd(8'h00, d);
        chk(d, 8'h00);
        // A write while the enable is low must be lost
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(PM_B_OFS, 8'h33);
        clk_en <= 1'b1;
        rd(PM_B_OFS, d);
        chk(d, PM_RESET);
        warm;
        tick(1);
        chk({port_on, peripheral_access_bit, sram_in_code_space_bit}, 3'b000);
        rd(PM_A_OFS, d);
        chk(d, 8'h5a);
        rd(MMAP_OFS, d);
        chk(d, REG_RESET);
        wr(PORT_EN_OFS, 8'h01);
        wr(PORT_EN_OFS, 8'h00);
        tick(1);
        chk(port_on, 1'b0);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            // Product term stands in for the cable's enable line
            {blank_device, port_select_product_term, nvm_port_dedicated} <= 3'b001 << i;
            tick(1);
            chk(port_on, 1'b1);
            @(posedge ref_clk);
            {blank_device, port_select_product_term, nvm_port_dedicated} <= 3'b000;
            tick(1);
            chk(port_on, 1'b0);
        end
        wr(PORT_EN_OFS, 8'h01);
        tick(2);
        chk({tdo_oe, isp_status_oe, isp_error_oe}, 3'b000);
        i_cable.scan(1'b1, OP_ISC_ENABLE, 8);
        chk(i_cable.tdo_seen[29:22], IR_CAPTURE);
        tick(1);
        chk({tdo_oe, isp_status_oe, isp_status_out}, 3'b111);
        i_cable.scan(1'b1, OP_ERASE, 8);
        i_cable.scan(1'b0, 16'h0200, 16);
        tick(1);
        chk({flash_op, flash_target, isp_status_out}, {FOP_ERASE, 8'h02, 1'b0});
        warm;
        chk({flash_abort, flash_op}, {1'b1, FOP_NONE});
        tick(1);
        chk(tdo_oe, 1'b0);
        @(posedge ref_clk);
        nvm_port_dedicated <= 1'b1;
        sector_protect <= 12'h008;
        i_cable.scan(1'b1, OP_ISC_ENABLE, 8);
        warm;
        chk(tdo_oe, 1'b1);
        i_cable.scan(1'b1, OP_PROGRAM, 8);
        i_cable.scan(1'b0, 16'h103c, 16);
        tick(1);
        chk({flash_op, flash_target, flash_wdata}, {FOP_PROGRAM, 16'h103c});
        done(1'b1);
        chk({isp_status_out, isp_error_out, flash_op}, {2'b10, FOP_NONE});
        warm;
        chk(isp_error_out, 1'b0);
        i_cable.scan(1'b1, OP_ISC_CLEAR, 8);
        tick(1);
        chk(isp_error_out, 1'b1);
        i_cable.scan(1'b1, OP_ERASE, 8);
        i_cable.scan(1'b0, 16'h0300, 16);
        tick(1);
        chk(flash_op, FOP_NONE);
        i_cable.scan(1'b0, 16'h0400, 16);
        tick(1);
        chk(flash_op, FOP_ERASE);
        done(1'b0);
        i_cable.scan(1'b1, OP_ISC_ENABLE_OD, 8);
        tick(1);
        chk({isp_status_oe, isp_status_out, isp_error_oe}, 3'b000);
        @(posedge ref_clk);
        security_bit <= 1'b1;
        i_cable.scan(1'b1, OP_PROGRAM, 8);
        i_cable.scan(1'b0, 16'h1055, 16);
        tick(1);
        chk(flash_op, FOP_NONE);
        i_cable.scan(1'b1, OP_READ, 8);
        i_cable.scan(1'b0, 16'h0000, 16);
        chk(i_cable.tdo_seen[21:14], 8'h00);
        i_cable.scan(1'b1, OP_CHIP_ERASE, 8);
        i_cable.scan(1'b0, 16'h0000, 1);
        tick(1);
        chk({flash_op, isp_status_oe, isp_status_out}, {FOP_CHIP, 2'b10});
        done(1'b0);
        i_cable.scan(1'b1, OP_READ, 8);
        i_cable.scan(1'b0, 16'h0000, 16);
        chk(i_cable.tdo_seen[21:14], 8'ha5);
        rd(STATUS_OFS, d);
        chk(d & 8'h70, 8'h60);
        // A failed write, then disable: only now does reset clear the error
        i_cable.scan(1'b1, OP_PROGRAM, 8);
        i_cable.scan(1'b0, 16'h0111, 16);
        done(1'b1);
        i_cable.scan(1'b1, OP_ISC_DISABLE, 8);
        rd(STATUS_OFS, d);
        chk(d[ST_ERR], 1'b1);
        warm;
        rd(STATUS_OFS, d);
        chk(d[ST_ERR], 1'b0);
        end_of_test;
    end

    // Whole sequence needs well under 100 us of cable traffic
    initial begin
        #300000;
        n_errors++;
        end_of_test;
    end
endmodule
